// ### lmio_pkg.sv
package lmio_pkg;

    localparam int LMIO_IW = 14;
    localparam int LMIO_DW = 8;
    localparam int LMIO_PW = 16;
    localparam int LMIO_BW = 5;
    localparam int LMIO_LW = 7;
    localparam int LMIO_AW = 4;
    localparam int LMIO_RW = 16;

    // Opcode patterns and masks of the instruction group
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] MK_NOP = 14'h3fff;
    localparam logic [13:0] OP_SWRST = 14'h0001;
    localparam logic [13:0] MK_SWRST = 14'h3fff;
    localparam logic [13:0] OP_LBANK = 14'h0020;
    localparam logic [13:0] MK_LBANK = 14'h3fe0;
    localparam logic [13:0] OP_LPCL = 14'h3180;
    localparam logic [13:0] MK_LPCL = 14'h3f80;
    localparam logic [13:0] OP_LWORK = 14'h3000;
    localparam logic [13:0] MK_LWORK = 14'h3f00;
    localparam logic [13:0] OP_STWF = 14'h0080;
    localparam logic [13:0] MK_STWF = 14'h3f80;
    localparam logic [13:0] OP_STWI = 14'h0018;
    localparam logic [13:0] MK_STWI = 14'h3ff8;
    localparam logic [13:0] OP_STWK = 14'h3f80;
    localparam logic [13:0] MK_STWK = 14'h3f80;

    // Operand field positions
    localparam int F_MODE_LO = 0;
    localparam int F_SEL_BIT = 2;
    localparam int F_REL_SEL = 6;
    localparam int F_OFS_W = 6;

    // File addresses of the two indirect windows
    localparam logic [6:0] INDIRECT_WINDOW0 = 7'h00;
    localparam logic [6:0] INDIRECT_WINDOW1 = 7'h01;

    // Register port offsets
    localparam logic [3:0] REG_BANK = 4'h0;
    localparam logic [3:0] REG_PCLATCH = 4'h1;
    localparam logic [3:0] REG_WORK = 4'h2;
    localparam logic [3:0] REG_PTR0 = 4'h3;
    localparam logic [3:0] REG_PTR1 = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_PWRCTL = 4'h6;
    localparam logic [3:0] REG_PC = 4'h7;

    // Reset values and pointer step
    localparam logic [4:0] RST_BANK = 5'h00;
    localparam logic [6:0] RST_PCLATCH = 7'h00;
    localparam logic [7:0] RST_WORK = 8'h00;
    localparam logic [15:0] RST_PTR = 16'h0000;
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic RST_RI = 1'b1;
    localparam logic [15:0] PTR_STEP = 16'h0001;

    typedef enum logic [1:0] {
        PM_PREINC = 2'b00,
        PM_PREDEC = 2'b01,
        PM_POSTINC = 2'b10,
        PM_POSTDEC = 2'b11
    } lmio_mode_type;

endpackage

// ### lmio_ptr_calc.sv
`timescale 1ns/100ps
module lmio_ptr_calc
    import lmio_pkg::*;
(
    input wire logic [15:0] ptr_i,
    input wire logic [1:0] pointer_mode_field_i,
    input wire logic rel_i,
    input wire logic [5:0] offset_i,
    output logic [15:0] addr_o,
    output logic [15:0] ptr_nxt_o
);
    logic [15:0] inc;
    logic [15:0] dec;
    logic [15:0] ofs;

    // Plain 16-bit adders wrap past the top and below zero
    assign inc = ptr_i + PTR_STEP; // [RULE_08]
    assign dec = ptr_i - PTR_STEP; // [RULE_08]
    assign ofs = ptr_i + {{(16 - F_OFS_W){offset_i[F_OFS_W - 1]}}, offset_i};

    always_comb begin
        addr_o = ptr_i;
        ptr_nxt_o = ptr_i;
        if (rel_i) begin
            addr_o = ofs; // [RULE_07]
            ptr_nxt_o = ptr_i; // [RULE_07]
        end else begin
            unique case (lmio_mode_type'(pointer_mode_field_i)) // [RULE_06]
                PM_PREINC: begin
                    addr_o = inc;
                    ptr_nxt_o = inc;
                end
                PM_PREDEC: begin
                    addr_o = dec;
                    ptr_nxt_o = dec;
                end
                PM_POSTINC: begin
                    addr_o = ptr_i;
                    ptr_nxt_o = inc;
                end
                PM_POSTDEC: begin
                    addr_o = ptr_i;
                    ptr_nxt_o = dec;
                end
            endcase
        end
    end
endmodule

// ### lmio_core.sv
// How it works
// [RULE_01] Bank literal load copies 5-bit immediate into bank select reg.
// [RULE_02] Latch literal load writes 7-bit immediate; status flags untouched.
// [RULE_03] Work literal load puts 8-bit immediate in work reg in one cycle.
// [RULE_04] File store writes work register to the 7-bit addressed file reg.
// [RULE_05] Indirect store writes work register where selected pointer points.
// [RULE_06] Mode field picks pre/post increment/decrement; new pointer kept.
// [RULE_07] Relative form adds signed offset -32..31; pointer unchanged.
// [RULE_08] Pointer is 16 bits and wraps at both ends.
// [RULE_09] Pointer adjustment changes no status bit.
// [RULE_10] Indirect windows have no storage; access goes to pointer address.
// [RULE_11] Software reset causes the same device reset as hardware sources.
// [RULE_12] Software reset clears reset-instruction flag in power control reg.
// [RULE_13] No-op takes one cycle, bumps program counter, changes nothing.
`timescale 1ns/100ps
module lmio_core
    import lmio_pkg::*;
#(
    parameter int DW = LMIO_DW
)
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [13:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic [4:0] bank_select_reg_o,
    output logic [6:0] pc_high_latch_o,
    output logic [DW-1:0] work_o,
    output logic [15:0] file_select_pointer0_o,
    output logic [15:0] file_select_pointer1_o,
    output logic [7:0] status_o,
    output logic reset_instr_flag_o,
    output logic [15:0] pc_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [DW-1:0] mem_wdata_o,
    output logic device_reset_o
);
    typedef struct packed {
        logic [4:0] bank;
        logic [6:0] pclatch;
        logic [DW-1:0] work;
        logic [15:0] ptr0;
        logic [15:0] ptr1;
        logic [7:0] status;
        logic ri;
        logic [15:0] pc;
        logic mem_we;
        logic [15:0] mem_addr;
        logic [DW-1:0] mem_wdata;
        logic dev_rst;
        logic [15:0] rdata;
    } lmio_state_type;

    lmio_state_type st_r;
    lmio_state_type st_nxt;

    function automatic logic is_op(input logic [13:0] ins,
        input logic [13:0] op, input logic [13:0] mk);
        is_op = (ins & mk) == op;
    endfunction

    logic dec_nop;
    logic dec_swrst;
    logic dec_lbank;
    logic dec_lpcl;
    logic dec_lwork;
    logic dec_stwf;
    logic dec_stwi;
    logic dec_stwk;
    logic ind_sel;
    logic [15:0] ind_ptr;
    logic [15:0] ind_addr;
    logic [15:0] ind_ptr_nxt;

    assign dec_nop = instr_valid_i && is_op(instr_i, OP_NOP, MK_NOP);
    assign dec_swrst = instr_valid_i && is_op(instr_i, OP_SWRST, MK_SWRST);
    assign dec_lbank = instr_valid_i && is_op(instr_i, OP_LBANK, MK_LBANK);
    assign dec_lpcl = instr_valid_i && is_op(instr_i, OP_LPCL, MK_LPCL);
    assign dec_lwork = instr_valid_i && is_op(instr_i, OP_LWORK, MK_LWORK);
    assign dec_stwf = instr_valid_i && is_op(instr_i, OP_STWF, MK_STWF);
    assign dec_stwi = instr_valid_i && is_op(instr_i, OP_STWI, MK_STWI);
    assign dec_stwk = instr_valid_i && is_op(instr_i, OP_STWK, MK_STWK);

    assign ind_sel = dec_stwk ? instr_i[F_REL_SEL] : instr_i[F_SEL_BIT];
    assign ind_ptr = ind_sel ? st_r.ptr1 : st_r.ptr0;

    lmio_ptr_calc u_ptr (
        .ptr_i(ind_ptr),
        .pointer_mode_field_i(instr_i[F_MODE_LO +: 2]),
        .rel_i(dec_stwk),
        .offset_i(instr_i[F_OFS_W - 1:0]),
        .addr_o(ind_addr),
        .ptr_nxt_o(ind_ptr_nxt)
    );

    always_comb begin
        st_nxt = st_r;
        st_nxt.mem_we = 1'b0;
        st_nxt.dev_rst = 1'b0;
        st_nxt.rdata = 16'h0000;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                REG_BANK: st_nxt.rdata = 16'(st_r.bank);
                REG_PCLATCH: st_nxt.rdata = 16'(st_r.pclatch);
                REG_WORK: st_nxt.rdata = 16'(st_r.work);
                REG_PTR0: st_nxt.rdata = st_r.ptr0;
                REG_PTR1: st_nxt.rdata = st_r.ptr1;
                REG_STATUS: st_nxt.rdata = 16'(st_r.status);
                REG_PWRCTL: st_nxt.rdata = 16'(st_r.ri);
                REG_PC: st_nxt.rdata = st_r.pc;
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        // Port writes first so a same-cycle instruction overrides them
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                REG_BANK: st_nxt.bank = reg_wdata_i[LMIO_BW-1:0];
                REG_PCLATCH: st_nxt.pclatch = reg_wdata_i[LMIO_LW-1:0];
                REG_WORK: st_nxt.work = reg_wdata_i[DW-1:0];
                REG_PTR0: st_nxt.ptr0 = reg_wdata_i;
                REG_PTR1: st_nxt.ptr1 = reg_wdata_i;
                REG_STATUS: st_nxt.status = reg_wdata_i[7:0];
                REG_PWRCTL: st_nxt.ri = reg_wdata_i[0];
                default: ;
            endcase
        end
        if (instr_valid_i) begin
            st_nxt.pc = st_r.pc + PTR_STEP; // [RULE_13]
        end
        if (dec_lbank) begin
            st_nxt.bank = instr_i[LMIO_BW-1:0]; // [RULE_01]
        end
        if (dec_lpcl) begin
            st_nxt.pclatch = instr_i[LMIO_LW-1:0]; // [RULE_02]
        end
        if (dec_lwork) begin
            st_nxt.work = instr_i[DW-1:0]; // [RULE_03]
        end
        if (dec_stwf) begin
            st_nxt.mem_we = 1'b1; // [RULE_04]
            st_nxt.mem_wdata = st_r.work;
            // No storage behind the windows: redirect to the pointers
            if (instr_i[6:0] == INDIRECT_WINDOW0) begin
                st_nxt.mem_addr = st_r.ptr0; // [RULE_10]
            end else if (instr_i[6:0] == INDIRECT_WINDOW1) begin
                st_nxt.mem_addr = st_r.ptr1; // [RULE_10]
            end else begin
                st_nxt.mem_addr = 16'({st_r.bank, instr_i[6:0]}); // [RULE_04]
            end
        end
        if (dec_stwi || dec_stwk) begin
            st_nxt.mem_we = 1'b1; // [RULE_05]
            st_nxt.mem_addr = ind_addr; // [RULE_05]
            st_nxt.mem_wdata = st_r.work;
            // Status is never touched here
            if (ind_sel) begin
                st_nxt.ptr1 = ind_ptr_nxt; // [RULE_06] [RULE_09]
            end else begin
                st_nxt.ptr0 = ind_ptr_nxt; // [RULE_06] [RULE_09]
            end
        end
        if (dec_swrst) begin
            // The flag is cleared with the rest of the state; read data this cycle are zero
            st_nxt = '0;
            st_nxt.bank = RST_BANK; // [RULE_11]
            st_nxt.pclatch = RST_PCLATCH;
            st_nxt.work = RST_WORK;
            st_nxt.ptr0 = RST_PTR;
            st_nxt.ptr1 = RST_PTR;
            st_nxt.status = RST_STATUS;
            st_nxt.pc = RST_PC;
            st_nxt.rdata = reg_rd_i ? 16'(st_r.ri) & 16'h0000 : 16'h0000;
            st_nxt.ri = 1'b0; // [RULE_12]
            st_nxt.dev_rst = 1'b1; // [RULE_11]
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= '0;
            st_r.bank <= RST_BANK;
            st_r.pclatch <= RST_PCLATCH;
            st_r.work <= RST_WORK;
            st_r.ptr0 <= RST_PTR;
            st_r.ptr1 <= RST_PTR;
            st_r.status <= RST_STATUS;
            st_r.pc <= RST_PC;
            st_r.ri <= RST_RI;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_o = st_r.rdata;
    assign bank_select_reg_o = st_r.bank;
    assign pc_high_latch_o = st_r.pclatch;
    assign work_o = st_r.work;
    assign file_select_pointer0_o = st_r.ptr0;
    assign file_select_pointer1_o = st_r.ptr1;
    assign status_o = st_r.status;
    assign reset_instr_flag_o = st_r.ri;
    assign pc_o = st_r.pc;
    assign mem_we_o = st_r.mem_we;
    assign mem_addr_o = st_r.mem_addr;
    assign mem_wdata_o = st_r.mem_wdata;
    assign device_reset_o = st_r.dev_rst;

    // Checks assume no port write hits a watched register in that cycle
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    chk_bank_load: assert property ( // [RULE_01]
        dec_lbank |=> bank_select_reg_o == $past(instr_i[4:0]))
        else $error("bank select not loaded");
    chk_latch_load: assert property ( // [RULE_02]
        dec_lpcl |=> pc_high_latch_o == $past(instr_i[6:0])
            && status_o == $past(status_o))
        else $error("pc latch load wrong");
    chk_work_load: assert property ( // [RULE_03]
        dec_lwork |=> work_o == $past(instr_i[7:0]) && $stable(status_o))
        else $error("work literal load wrong");
    chk_file_store: assert property ( // [RULE_04]
        dec_stwf && instr_i[6:1] != 6'h00 |=> mem_we_o
            && mem_wdata_o == $past(work_o)
            && mem_addr_o == {4'h0, $past(bank_select_reg_o),
                $past(instr_i[6:0])})
        else $error("file store wrong");
    chk_ind_store: assert property ( // [RULE_05]
        (dec_stwi || dec_stwk) |=> mem_we_o
            && mem_wdata_o == $past(work_o) && $stable(status_o))
        else $error("indirect store wrong");
    chk_postinc_ptr: assert property ( // [RULE_06]
        dec_stwi && !instr_i[2] && instr_i[1:0] == 2'b10
        |=> file_select_pointer0_o == $past(file_select_pointer0_o) + 16'h1
            && mem_addr_o == $past(file_select_pointer0_o))
        else $error("postincrement wrong");
    chk_predec_wrap: assert property ( // [RULE_08]
        dec_stwi && instr_i[2] && instr_i[1:0] == 2'b01
            && file_select_pointer1_o == 16'h0000
        |=> file_select_pointer1_o == 16'hffff && mem_addr_o == 16'hffff)
        else $error("predecrement wrap wrong");
    chk_rel_keep: assert property ( // [RULE_07]
        dec_stwk && !instr_i[6] |=> $stable(file_select_pointer0_o)
            && mem_addr_o == $past(file_select_pointer0_o)
                + {{10{$past(instr_i[5])}}, $past(instr_i[5:0])})
        else $error("relative store wrong");
    chk_window_redir: assert property ( // [RULE_10]
        dec_stwf && instr_i[6:0] == 7'h01
        |=> mem_addr_o == $past(file_select_pointer1_o))
        else $error("window not redirected");
    chk_sw_reset: assert property ( // [RULE_11] [RULE_12]
        dec_swrst |=> device_reset_o && !reset_instr_flag_o
            && pc_o == 16'h0000 ##1 !device_reset_o)
        else $error("software reset wrong");
    chk_nop_quiet: assert property ( // [RULE_13]
        dec_nop && !reg_wr_i |=> pc_o == $past(pc_o) + 16'h1
            && !mem_we_o && $stable(work_o) && $stable(bank_select_reg_o))
        else $error("nop changed state");
    chk_no_flag_move: assert property ( // [RULE_09]
        !(reg_wr_i && reg_addr_i == REG_STATUS) && !dec_swrst
        |=> $stable(status_o))
        else $error("status changed");
    chk_preinc_wrap: assert property ( // [RULE_08]
        dec_stwi && !instr_i[F_SEL_BIT] && instr_i[1:0] == 2'b00
            && file_select_pointer0_o == 16'hffff
        |=> file_select_pointer0_o == 16'h0000 && mem_addr_o == 16'h0000)
        else $error("preincrement wrap wrong");
    chk_postdec_wrap: assert property ( // [RULE_08]
        dec_stwi && instr_i[F_SEL_BIT] && instr_i[1:0] == 2'b11
            && file_select_pointer1_o == 16'h0000
        |=> file_select_pointer1_o == 16'hffff && mem_addr_o == 16'h0000)
        else $error("postdecrement wrap wrong");
    chk_rel_ptr1: assert property ( // [RULE_07]
        dec_stwk && instr_i[F_REL_SEL] |=> $stable(file_select_pointer1_o)
            && mem_addr_o == $past(file_select_pointer1_o)
                + {{10{$past(instr_i[5])}}, $past(instr_i[5:0])})
        else $error("relative store on second pointer wrong");
    // Only the file store can name a window; no other op here has f
    chk_window0_redir: assert property ( // [RULE_10]
        dec_stwf && instr_i[6:0] == INDIRECT_WINDOW0
        |=> mem_addr_o == $past(file_select_pointer0_o))
        else $error("first window not redirected");
    chk_other_ptr_kept: assert property ( // [RULE_06]
        dec_stwi && !instr_i[F_SEL_BIT] && !(reg_wr_i && reg_addr_i == REG_PTR1)
        |=> $stable(file_select_pointer1_o))
        else $error("unselected pointer moved");
    chk_sw_reset_regs: assert property ( // [RULE_11]
        dec_swrst |=> bank_select_reg_o == RST_BANK && work_o == RST_WORK
            && pc_high_latch_o == RST_PCLATCH
            && file_select_pointer0_o == RST_PTR
            && file_select_pointer1_o == RST_PTR)
        else $error("software reset left state");

    // Bottom wrap of the second pointer is the case most easily missed
    cov_ind_store: cover property (dec_stwi ##1 dec_stwi);
    cov_rel_store: cover property (dec_stwk && instr_i[5]);
    cov_sw_reset: cover property (dec_swrst);
    cov_literals: cover property (dec_lwork ##1 dec_stwf);
    cov_ptr_wrap: cover property (dec_stwi && file_select_pointer1_o == '0);
endmodule

// ### lmio_prog_mem.sv
`timescale 1ns/100ps
module lmio_prog_mem
    import lmio_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] pc_i,
    input wire logic run_i,
    input wire logic gap_i,
    output logic [13:0] instr_o,
    output logic instr_valid_o
);
    logic [13:0] mem [0:63];
    logic phase_r;
    logic [13:0] churn;
    // Slow mode fetches every other cycle
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_r <= 1'b1;
        end else begin
            phase_r <= run_i ? ~phase_r : 1'b1;
        end
    end
    // Word bus churns between fetches so a stale word never looks usable
    assign churn = 14'h2aaa ^ {14{phase_r}};
    assign instr_valid_o = run_i & (~gap_i | phase_r);
    assign instr_o = instr_valid_o ? mem[pc_i[5:0]] : churn;
endmodule

// ### tb_literal_move_indirect_ops.sv
`timescale 1ns/100ps
module tb_literal_move_indirect_ops;
    import lmio_pkg::*;
    logic clk_i, resetn_i, reg_wr_i, reg_rd_i, run, gap;
    logic [3:0] reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, ptr0, ptr1, pc_o, mem_addr_o;
    logic [13:0] instr;
    logic instr_valid, flag, mem_we_o, device_reset_o;
    logic [4:0] bank;
    logic [6:0] latch;
    logic [7:0] work, status, wdata;
    logic [15:0] epc, s, a, p;
    logic [1:0] md;
    int error_cnt, checks, m;

    lmio_prog_mem pm (.clk_i(clk_i), .resetn_i(resetn_i), .pc_i(pc_o),
        .run_i(run), .gap_i(gap), .instr_o(instr),
        .instr_valid_o(instr_valid));

    lmio_core DUT (.clk_i(clk_i), .resetn_i(resetn_i), .instr_i(instr),
        .instr_valid_i(instr_valid), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .bank_select_reg_o(bank),
        .pc_high_latch_o(latch), .work_o(work),
        .file_select_pointer0_o(ptr0), .file_select_pointer1_o(ptr1),
        .status_o(status), .reset_instr_flag_o(flag), .pc_o(pc_o),
        .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(wdata), .device_reset_o(device_reset_o));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task report_and_stop;
        if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task wr(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd(input logic [3:0] ad, input logic [15:0] exp);
        @(posedge clk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 cmp(reg_rdata_o, exp);
    endtask

    task put(input logic [5:0] i, input logic [13:0] w);
        pm.mem[epc[5:0] + i] = w;
    endtask

    task go(input int n, input logic g);
        @(posedge clk_i);
        run <= 1'b1;
        gap <= g;
        repeat (g ? 2 * n : n) @(posedge clk_i);
        run <= 1'b0;
        gap <= 1'b0;
        epc = epc + 16'(n);
        #1;
    endtask

    task exec(input logic [13:0] w);
        put(6'h00, w);
        go(1, 1'b0);
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        error_cnt++;
        report_and_stop;
    end

    initial begin
        resetn_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 16'h0000;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        run = 1'b0;
        gap = 1'b0;
        error_cnt = 0;
        checks = 0;
        epc = 16'h0000;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (m = 0; m < 9; m++) begin
            rd(m[3:0], (m == 6) ? 16'h0001 : 16'h0000);
        end
        wr(REG_STATUS, 16'h005a);
        wr(REG_PC, 16'h1234);
        wr(4'hf, 16'hffff);
        rd(REG_PC, 16'h0000);
        rd(4'hf, 16'h0000);
        // Back-to-back literals fetched slowly
        put(6'h00, OP_LBANK | 14'h001f);
        put(6'h01, OP_LPCL | 14'h007f);
        put(6'h02, OP_LWORK | 14'h00a5);
        put(6'h03, OP_NOP);
        go(4, 1'b1);
        cmp({11'h000, bank}, 16'h001f);
        cmp({9'h000, latch}, 16'h007f);
        cmp({8'h00, work}, 16'h00a5);
        cmp({8'h00, status}, 16'h005a);
        cmp(pc_o, epc);
        exec(OP_NOP);
        cmp(pc_o, epc);
        cmp({15'h0000, mem_we_o}, 16'h0000);
        cmp({8'h00, work}, 16'h00a5);
        exec(OP_STWF | 14'h0045);
        cmp({15'h0000, mem_we_o}, 16'h0001);
        cmp(mem_addr_o, 16'h0fc5);
        cmp({8'h00, wdata}, 16'h00a5);
        cmp(pc_o, epc);
        @(posedge clk_i);
        #1 cmp({15'h0000, mem_we_o}, 16'h0000);
        wr(REG_PTR0, 16'h1234);
        wr(REG_PTR1, 16'h4321);
        exec(OP_STWF | {7'h00, INDIRECT_WINDOW0});
        cmp(mem_addr_o, 16'h1234);
        exec(OP_STWF | {7'h00, INDIRECT_WINDOW1});
        cmp(mem_addr_o, 16'h4321);
        // Start each mode at the edge its step crosses; pointers alternate
        for (m = 0; m < 4; m++) begin
            md = m[1:0];
            s = md[0] ? 16'h0000 : 16'hffff;
            p = md[0] ? s - PTR_STEP : s + PTR_STEP;
            a = md[1] ? s : p;
            wr(REG_PTR0 + {3'h0, md[0]}, s);
            exec(OP_STWI | {11'h000, md[0], md});
            cmp(mem_addr_o, a);
            cmp(md[0] ? ptr1 : ptr0, p);
            cmp({8'h00, wdata}, 16'h00a5);
            cmp({15'h0000, mem_we_o}, 16'h0001);
        end
        rd(REG_STATUS, 16'h005a);
        wr(REG_PTR1, 16'h0010);
        exec(OP_STWK | 14'h0060);
        cmp(mem_addr_o, 16'hfff0);
        cmp(ptr1, 16'h0010);
        wr(REG_PTR0, 16'hffff);
        exec(OP_STWK | 14'h001f);
        cmp(mem_addr_o, 16'h001e);
        cmp(ptr0, 16'hffff);
        exec(OP_SWRST);
        epc = 16'h0000;
        cmp({15'h0000, device_reset_o}, 16'h0001);
        cmp({15'h0000, flag}, 16'h0000);
        cmp({11'h000, bank}, 16'h0000);
        cmp(pc_o, 16'h0000);
        @(posedge clk_i);
        #1 cmp({15'h0000, device_reset_o}, 16'h0000);
        rd(REG_PWRCTL, 16'h0000);
        rd(REG_PTR0, 16'h0000);
        wr(REG_PWRCTL, 16'h0001);
        rd(REG_PWRCTL, 16'h0001);
        report_and_stop;
    end
endmodule
